// >>> core/aio_pkg.sv
// Purpose: shared constants and types for the accessory i/o command port
// Assumes: 25 MHz clock, ahb-lite register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package aio_pkg;
   // register byte offsets
   localparam logic [7:0] AIO_OFF_CTRL   = 8'h00;
   localparam logic [7:0] AIO_OFF_OUTS   = 8'h04;
   localparam logic [7:0] AIO_OFF_CMD    = 8'h08;
   localparam logic [7:0] AIO_OFF_STATUS = 8'h0C;
   localparam logic [7:0] AIO_OFF_REPLY  = 8'h10;
   // ctrl field positions
   localparam int AIO_CTRL_MODE_LSB  = 0;
   localparam int AIO_CTRL_FUNC_LSB  = 2;
   localparam int AIO_CTRL_POS_BIT   = 4;
   // reset values
   localparam logic [31:0] AIO_CTRL_RST = 32'h0000_0001;
   localparam logic [1:0]  AIO_OUTS_RST = 2'b00;
   // radio stick threshold: pulse widths in cycles at 25 MHz
   localparam int AIO_CLK_MHZ      = 25;
   localparam int AIO_STICK_HI_US  = 1700;
   localparam int AIO_STICK_LO_US  = 1300;
   localparam int AIO_STICK_HI_CYC = AIO_STICK_HI_US * AIO_CLK_MHZ;
   localparam int AIO_STICK_LO_CYC = AIO_STICK_LO_US * AIO_CLK_MHZ;
   // serial command characters
   localparam logic [7:0] AIO_CH_C_ON  = 8'h43;
   localparam logic [7:0] AIO_CH_C_OFF = 8'h63;
   localparam logic [7:0] AIO_CH_D_ON  = 8'h44;
   localparam logic [7:0] AIO_CH_D_OFF = 8'h64;
   localparam logic [7:0] AIO_CH_BANG  = 8'h21;
   localparam logic [7:0] AIO_FLD_OFF  = 8'h00;
   localparam logic [7:0] AIO_FLD_ON   = 8'h01;

   typedef enum logic [1:0] {
      AIO_MODE_RADIO  = 2'b00,
      AIO_MODE_SERIAL = 2'b01,
      AIO_MODE_ANALOG = 2'b10
   } aio_mode_e;

   typedef enum logic [1:0] {
      AIO_FN_NONE   = 2'b00,
      AIO_FN_STOP   = 2'b01,
      AIO_FN_INVERT = 2'b10
   } aio_func_e;

   typedef enum logic [0:0] {
      AIO_PS_IDLE = 1'b0,
      AIO_PS_BANG = 1'b1
   } aio_parse_e;

   // ahb-lite request as the slave sees it
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
   } aio_ahb_req_s;

   // synchronised pin levels
   typedef struct packed {
      logic pullup_in;
      logic opto_in;
      logic stop_or_flip_input;
      logic radio_ch3;
   } aio_pins_s;
endpackage

// >>> core/aio_port.sv
// Purpose: accessory outputs, general inputs, stop/flip input and pin routing
// Assumes: pins are asynchronous and pass two flip-flops before use
// Notes:   serial bytes arrive already framed on a byte strobe
//
// The address map and the AHB-Lite slave port are this design's own decisions.
module aio_port #(
   parameter int STICK_HI = aio_pkg::AIO_STICK_HI_CYC,
   parameter int STICK_LO = aio_pkg::AIO_STICK_LO_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        PULLUP_PIN,
   input  wire logic        OPTO_PIN,
   input  wire logic        STOP_FLIP_PIN,
   input  wire logic        SERIAL_IN_PIN,
   input  wire logic        RX_VALID,
   input  wire logic [7:0]  RX_BYTE,
   output logic             HI_OUT_OE_N,
   output logic             LO_OUT,
   output logic             RADIO_CH1,
   output logic             RADIO_CH2,
   output logic             RADIO_CH3,
   output logic             MOTOR_STOP,
   output logic             MOTOR_INVERT,
   output logic             ANALOG_IS_CMD,
   output logic             ANALOG_IS_POS
);
   import aio_pkg::*;

   // two-flop synchronisers; first stage feeds only the second
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] pins_raw;
   assign pins_raw = {SERIAL_IN_PIN, STOP_FLIP_PIN, OPTO_PIN, PULLUP_PIN};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge CLOCK) begin
            if (RST) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pins_raw[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   aio_pins_s pins;
   logic      serial_in;
   assign pins.pullup_in          = sync2[0];  // pull-up: floating reads 1 = On
   assign pins.opto_in            = sync2[1];  // opto: floating reads 0 = Off
   assign pins.stop_or_flip_input = sync2[2];  // high = On = inactive
   assign pins.radio_ch3          = sync2[0];
   assign serial_in               = sync2[3];

   // registers
   logic [31:0] ctrl;
   logic [1:0]  outs;
   logic [23:0] reply;
   logic        reply_new;
   aio_mode_e   mode;
   aio_func_e   func;
   assign mode = aio_mode_e'(ctrl[AIO_CTRL_MODE_LSB +: 2]);
   assign func = aio_func_e'(ctrl[AIO_CTRL_FUNC_LSB +: 2]);

   // pin routing per command mode
   assign RADIO_CH3 = (mode == AIO_MODE_RADIO) & pins.radio_ch3;
   assign RADIO_CH2 = (mode == AIO_MODE_RADIO) & pins.opto_in;
   assign RADIO_CH1 = (mode == AIO_MODE_RADIO) & serial_in;
   assign ANALOG_IS_CMD = (mode == AIO_MODE_ANALOG);
   assign ANALOG_IS_POS = (mode != AIO_MODE_ANALOG) & ctrl[AIO_CTRL_POS_BIT];

   // stop/flip function; active low, no action after reset
   logic flip_active;
   assign flip_active  = ~pins.stop_or_flip_input;
   assign MOTOR_STOP   = (func == AIO_FN_STOP) & flip_active;
   assign MOTOR_INVERT = (func == AIO_FN_INVERT) & flip_active;

   // user-input visibility: radio mode hides pins that carry pulses
   logic user_pullup;
   logic user_opto;
   assign user_pullup = (mode != AIO_MODE_RADIO) & pins.pullup_in;
   assign user_opto   = (mode == AIO_MODE_SERIAL) & pins.opto_in;

   // radio channel 3 pulse width measurement; 24 bits cover a frame gap
   logic [23:0] pw_cnt;
   logic        ch3_d;
   logic        stick_hi;
   logic        stick_lo;
   logic        stick_hi_d;
   logic        pulse_end;
   assign pulse_end = ch3_d & ~RADIO_CH3;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pw_cnt <= 24'h00_0000;
         ch3_d  <= 1'b0;
      end else begin
         ch3_d  <= RADIO_CH3;
         pw_cnt <= RADIO_CH3 ? pw_cnt + 24'h00_0001 : 24'h00_0000;
      end
   end

   // classify each completed pulse; band between keeps stick_hi, clears stick_lo
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         stick_hi   <= 1'b0;
         stick_lo   <= 1'b0;
         stick_hi_d <= 1'b0;
      end else begin
         stick_hi_d <= stick_hi;
         if (pulse_end) begin
            stick_hi <= (pw_cnt >= 24'(STICK_HI)) | (stick_hi & (pw_cnt > 24'(STICK_LO)));
            stick_lo <= pw_cnt <= 24'(STICK_LO);
         end
      end
   end

   // serial command parser: bang then letter
   aio_parse_e ps;
   aio_parse_e next_ps;
   logic       cmd_c_on;
   logic       cmd_c_off;
   logic       cmd_d_on;
   logic       cmd_d_off;
   logic       ser_ok;
   assign ser_ok    = (mode == AIO_MODE_SERIAL) & RX_VALID & (ps == AIO_PS_BANG);
   assign cmd_c_on  = ser_ok & (RX_BYTE == AIO_CH_C_ON);
   assign cmd_c_off = ser_ok & (RX_BYTE == AIO_CH_C_OFF);
   assign cmd_d_on  = ser_ok & (RX_BYTE == AIO_CH_D_ON);
   assign cmd_d_off = ser_ok & (RX_BYTE == AIO_CH_D_OFF);
   always_comb begin
      next_ps = ps;
      case (ps)
         AIO_PS_IDLE: if (RX_VALID && RX_BYTE == AIO_CH_BANG) next_ps = AIO_PS_BANG;
         AIO_PS_BANG: if (RX_VALID) next_ps = (RX_BYTE == AIO_CH_BANG) ? AIO_PS_BANG : AIO_PS_IDLE;
         default:     next_ps = AIO_PS_IDLE;
      endcase
   end
   always_ff @(posedge CLOCK) begin
      if (RST) ps <= AIO_PS_IDLE;
      else     ps <= next_ps;
   end

   // ahb-lite slave: address phase captured, zero wait state
   aio_ahb_req_s req;
   logic         ph_valid;
   logic         ph_write;
   logic [7:0]   ph_addr;
   logic         wr_ctrl;
   logic         wr_outs;
   logic         rd_reply;
   logic         query;
   assign req = '{hsel: HSEL, haddr: HADDR, htrans: HTRANS, hwrite: HWRITE, hsize: HSIZE, hready: HREADY};
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign wr_ctrl   = ph_valid & ph_write & (ph_addr == AIO_OFF_CTRL);
   assign wr_outs   = ph_valid & ph_write & (ph_addr == AIO_OFF_OUTS);
   // writing the query command samples inputs; a serial query byte does too
   assign query     = (ph_valid & ph_write & (ph_addr == AIO_OFF_CMD))
                    | ((mode == AIO_MODE_SERIAL) & RX_VALID & (ps == AIO_PS_IDLE) & (RX_BYTE == 8'h3F));
   assign rd_reply  = ph_valid & ~ph_write & (ph_addr == AIO_OFF_REPLY);
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else begin
         ph_valid <= req.hsel & req.hready & req.htrans[1];
         ph_write <= req.hwrite;
         ph_addr  <= req.haddr[7:0];
      end
   end

   // control register; reset gives serial mode, no-action function
   always_ff @(posedge CLOCK) begin
      if (RST)          ctrl <= AIO_CTRL_RST;
      else if (wr_ctrl) ctrl <= {27'h000_0000, HWDATA[4:0]};
   end

   // accessory outputs: bit0 high-current, bit1 low-current
   logic [1:0] next_outs;
   always_comb begin
      next_outs = outs;
      if (mode == AIO_MODE_RADIO) begin
         next_outs[0] = stick_hi;
         if (stick_hi & ~stick_hi_d) next_outs[1] = ~outs[1];
      end else begin
         if (wr_outs) next_outs = HWDATA[1:0];
         if (cmd_c_on)  next_outs[0] = 1'b1;
         if (cmd_c_off) next_outs[0] = 1'b0;
         if (cmd_d_on)  next_outs[1] = 1'b1;
         if (cmd_d_off) next_outs[1] = 1'b0;
      end
   end
   always_ff @(posedge CLOCK) begin
      if (RST) outs <= AIO_OUTS_RST;
      else     outs <= next_outs;
   end
   assign HI_OUT_OE_N = ~outs[0];   // open drain: enable low pulls the load on
   assign LO_OUT      = outs[1];

   // query reply: three two-digit fields, sampled at the query
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         reply     <= 24'h00_0000;
         reply_new <= 1'b0;
      end else begin
         if (query) begin
            reply[23:16] <= user_pullup ? AIO_FLD_ON : AIO_FLD_OFF;
            reply[15:8]  <= user_opto ? AIO_FLD_ON : AIO_FLD_OFF;
            reply[7:0]   <= pins.stop_or_flip_input ? AIO_FLD_ON : AIO_FLD_OFF;
         end
         // set wins over the clear-on-read
         if (query)         reply_new <= 1'b1;
         else if (rd_reply) reply_new <= 1'b0;
      end
   end

   // read mux
   logic [31:0] rd_mux;
   assign rd_mux = (ph_addr == AIO_OFF_CTRL)   ? ctrl :
                   (ph_addr == AIO_OFF_OUTS)   ? {30'h0000_0000, outs} :
                   (ph_addr == AIO_OFF_STATUS) ? {25'h000_0000, stick_lo, stick_hi, MOTOR_INVERT,
                                                  MOTOR_STOP, pins.stop_or_flip_input, user_opto, user_pullup} :
                   (ph_addr == AIO_OFF_REPLY)  ? {7'h00, reply_new, reply} : 32'h0000_0000;
   assign HRDATA = (ph_valid & ~ph_write) ? rd_mux : 32'h0000_0000;

   // checks
   property p_stop_needs_low;
      @(posedge CLOCK) disable iff (RST) MOTOR_STOP |-> !pins.stop_or_flip_input;
   endproperty
   a_stop_needs_low: assert property (p_stop_needs_low) else $error("stop without low input");
   property p_c_on;
      @(posedge CLOCK) disable iff (RST) cmd_c_on |=> !HI_OUT_OE_N;
   endproperty
   a_c_on: assert property (p_c_on) else $error("high output not on");
   property p_d_off;
      @(posedge CLOCK) disable iff (RST) cmd_d_off && !cmd_d_on |=> !LO_OUT;
   endproperty
   a_d_off: assert property (p_d_off) else $error("low output not off");
   property p_radio_follow;
      @(posedge CLOCK) disable iff (RST) mode == AIO_MODE_RADIO |=> HI_OUT_OE_N == !$past(stick_hi);
   endproperty
   a_radio_follow: assert property (p_radio_follow) else $error("high output not following stick");
   property p_toggle;
      @(posedge CLOCK) disable iff (RST) (mode == AIO_MODE_RADIO) && stick_hi && !stick_hi_d |=> LO_OUT != $past(LO_OUT);
   endproperty
   a_toggle: assert property (p_toggle) else $error("low output did not toggle");
   property p_reply_f3;
      @(posedge CLOCK) disable iff (RST) query |=> reply[0] == $past(pins.stop_or_flip_input);
   endproperty
   a_reply_f3: assert property (p_reply_f3) else $error("field three wrong");
   property p_reply_f1;
      @(posedge CLOCK) disable iff (RST) query |=> reply[16] == $past(user_pullup);
   endproperty
   a_reply_f1: assert property (p_reply_f1) else $error("field one wrong");
   property p_invert;
      @(posedge CLOCK) disable iff (RST) MOTOR_INVERT |-> func == AIO_FN_INVERT && !MOTOR_STOP;
   endproperty
   a_invert: assert property (p_invert) else $error("invert with wrong function");

   // accessory outputs: commands land next edge, otherwise they hold outside radio mode
   property p_c_off;
      @(posedge CLOCK) disable iff (RST) cmd_c_off |=> HI_OUT_OE_N;
   endproperty
   a_c_off: assert property (p_c_off) else $error("high output not off");
   property p_d_on;
      @(posedge CLOCK) disable iff (RST) cmd_d_on |=> LO_OUT;
   endproperty
   a_d_on: assert property (p_d_on) else $error("low output not on");
   property p_serial_hold;
      @(posedge CLOCK) disable iff (RST)
         (mode != AIO_MODE_RADIO) && !ser_ok && !wr_outs |=> $stable(HI_OUT_OE_N) && $stable(LO_OUT);
   endproperty
   a_serial_hold: assert property (p_serial_hold) else $error("output moved without command");
   property p_lo_hold_radio;
      @(posedge CLOCK) disable iff (RST) (mode == AIO_MODE_RADIO) && !(stick_hi && !stick_hi_d) |=> $stable(LO_OUT);
   endproperty
   a_lo_hold_radio: assert property (p_lo_hold_radio) else $error("low output toggled without stick");
   property p_no_cmd_outside;
      @(posedge CLOCK) disable iff (RST)
         (mode != AIO_MODE_SERIAL) |-> !cmd_c_on && !cmd_c_off && !cmd_d_on && !cmd_d_off;
   endproperty
   a_no_cmd_outside: assert property (p_no_cmd_outside) else $error("command outside serial mode");
   property p_stick_excl;
      @(posedge CLOCK) disable iff (RST) !(stick_hi && stick_lo);
   endproperty
   a_stick_excl: assert property (p_stick_excl) else $error("stick both high and low");

   // pin routing: pulse lines only reach the receiver side in radio mode
   property p_ch3_gate;
      @(posedge CLOCK) disable iff (RST) (mode != AIO_MODE_RADIO) |-> !RADIO_CH3;
   endproperty
   a_ch3_gate: assert property (p_ch3_gate) else $error("channel three outside radio");
   property p_ch3_pin;
      @(posedge CLOCK) disable iff (RST) (mode == AIO_MODE_RADIO) |-> RADIO_CH3 == pins.pullup_in;
   endproperty
   a_ch3_pin: assert property (p_ch3_pin) else $error("channel three not from pull-up pin");
   property p_ch2_gate;
      @(posedge CLOCK) disable iff (RST) (mode != AIO_MODE_RADIO) |-> !RADIO_CH2;
   endproperty
   a_ch2_gate: assert property (p_ch2_gate) else $error("channel two outside radio");
   property p_ch1_gate;
      @(posedge CLOCK) disable iff (RST) (mode != AIO_MODE_RADIO) |-> !RADIO_CH1;
   endproperty
   a_ch1_gate: assert property (p_ch1_gate) else $error("channel one outside radio");
   property p_analog_cmd;
      @(posedge CLOCK) disable iff (RST) ANALOG_IS_CMD |-> !ANALOG_IS_POS;
   endproperty
   a_analog_cmd: assert property (p_analog_cmd) else $error("analog command and feedback at once");
   property p_pos_feedback;
      @(posedge CLOCK) disable iff (RST) ANALOG_IS_POS |-> ctrl[AIO_CTRL_POS_BIT];
   endproperty
   a_pos_feedback: assert property (p_pos_feedback) else $error("position feedback not selected");

   // query reply: hidden inputs read off, fields only 00 or 01
   property p_radio_hides_f1;
      @(posedge CLOCK) disable iff (RST) query && (mode == AIO_MODE_RADIO) |=> reply[23:16] == AIO_FLD_OFF;
   endproperty
   a_radio_hides_f1: assert property (p_radio_hides_f1) else $error("field one visible in radio");
   property p_opto_hides_f2;
      @(posedge CLOCK) disable iff (RST) query && (mode != AIO_MODE_SERIAL) |=> reply[15:8] == AIO_FLD_OFF;
   endproperty
   a_opto_hides_f2: assert property (p_opto_hides_f2) else $error("field two visible outside serial");
   property p_reply_f2;
      @(posedge CLOCK) disable iff (RST) query |=> reply[8] == $past(user_opto);
   endproperty
   a_reply_f2: assert property (p_reply_f2) else $error("field two wrong");
   property p_field_codes;
      @(posedge CLOCK) disable iff (RST) reply[23:17] == 7'h00 && reply[15:9] == 7'h00 && reply[7:1] == 7'h00;
   endproperty
   a_field_codes: assert property (p_field_codes) else $error("reply field not 00 or 01");
   property p_reply_hold;
      @(posedge CLOCK) disable iff (RST) !query |=> $stable(reply);
   endproperty
   a_reply_hold: assert property (p_reply_hold) else $error("reply changed without query");
   property p_new_set;
      @(posedge CLOCK) disable iff (RST) query |=> reply_new;
   endproperty
   a_new_set: assert property (p_new_set) else $error("new flag not set by query");

   // stop/flip function: only the selected action, only when pulled low
   property p_none_quiet;
      @(posedge CLOCK) disable iff (RST) (func == AIO_FN_NONE) |-> !MOTOR_STOP && !MOTOR_INVERT;
   endproperty
   a_none_quiet: assert property (p_none_quiet) else $error("action with no function");
   property p_float_quiet;
      @(posedge CLOCK) disable iff (RST) pins.stop_or_flip_input |-> !MOTOR_STOP && !MOTOR_INVERT;
   endproperty
   a_float_quiet: assert property (p_float_quiet) else $error("action with input high");
   property p_invert_low;
      @(posedge CLOCK) disable iff (RST) (func == AIO_FN_INVERT) && !pins.stop_or_flip_input |-> MOTOR_INVERT;
   endproperty
   a_invert_low: assert property (p_invert_low) else $error("invert missed");
   property p_stop_low;
      @(posedge CLOCK) disable iff (RST) (func == AIO_FN_STOP) && !pins.stop_or_flip_input |-> MOTOR_STOP;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("stop missed");
endmodule

// >>> tb/aio_host.sv
// Purpose: host and radio receiver model on the far side of the accessory port
// Assumes: serial bytes arrive framed, one per strobe, on the port clock
// Notes:   idle byte lines carry the inverse of the last byte, never a stale copy
module aio_host (
   input  wire logic       CLOCK,
   output logic            RX_VALID,
   output logic [7:0]      RX_BYTE,
   output logic            CH3_PULSE
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet link and receiver at time zero
   initial begin
      RX_VALID = 1'b0;
      RX_BYTE = 8'h00;
      CH3_PULSE = 1'b0;
   end

   // bang then letter on back-to-back strobes; upper case on, lower case off
   task automatic send_cmd(input logic [7:0] c);
      RX_VALID <= 1'b1;
      RX_BYTE <= aio_pkg::AIO_CH_BANG;
      @(posedge CLOCK);
      RX_BYTE <= c;
      @(posedge CLOCK);
      RX_VALID <= 1'b0;
      RX_BYTE <= ~c;
      @(posedge CLOCK);
   endtask

   // a lone byte on one strobe, such as the status query
   task automatic send_byte(input logic [7:0] b);
      RX_VALID <= 1'b1;
      RX_BYTE <= b;
      @(posedge CLOCK);
      RX_VALID <= 1'b0;
      RX_BYTE <= ~b;
      @(posedge CLOCK);
   endtask

   // one channel-three pulse, then a low gap so the port can judge its width
   task automatic stick(input int w);
      CH3_PULSE <= 1'b1;
      repeat (w) @(posedge CLOCK);
      CH3_PULSE <= 1'b0;
      repeat (40) @(posedge CLOCK);
   endtask
endmodule

// >>> tb/aio_port_test.sv
// Purpose: self-checking bench for the accessory i/o command port
// Assumes: slave answers with hreadyout, bench waits for it under a bound
// Notes:   stick thresholds shortened to keep radio pulses brief
module aio_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import aio_pkg::*;

   localparam int HI_W = 20;
   localparam int LO_W = 10;

   logic        clock, rst, hsel, hwrite, hreadyout, hresp, pullup_lvl, opto, stop_n, ser_in, radio_on;
   logic        rx_valid, ch3, hi_oe_n, lo_out, ch1_o, ch2_o, ch3_o, m_stop, m_inv, is_cmd, is_pos;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  rx_byte;
   wire logic   pullup_pin;
   int          failures, num_checks;

   // the pull-up pin is the channel-three line while the receiver owns it
   assign pullup_pin = radio_on ? ch3 : pullup_lvl;

   aio_port #(.STICK_HI(HI_W), .STICK_LO(LO_W)) DUT (
      .CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .PULLUP_PIN(pullup_pin), .OPTO_PIN(opto), .STOP_FLIP_PIN(stop_n),
      .SERIAL_IN_PIN(ser_in), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .HI_OUT_OE_N(hi_oe_n),
      .LO_OUT(lo_out), .RADIO_CH1(ch1_o), .RADIO_CH2(ch2_o), .RADIO_CH3(ch3_o), .MOTOR_STOP(m_stop),
      .MOTOR_INVERT(m_inv), .ANALOG_IS_CMD(is_cmd), .ANALOG_IS_POS(is_pos)
   );

   aio_host host (.CLOCK(clock), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .CH3_PULSE(ch3));

   // 25 mhz
   always #20 clock = ~clock;

   task automatic wrap_up;
      if (failures == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // bounded wait for hready; a hang is a failure, not a stall
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         wrap_up();
      end
   endtask

   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      hsize <= 3'b010;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic settle;
      repeat (4) @(posedge clock);
   endtask

   task automatic t_reset;
      ahb(1'b0, AIO_OFF_CTRL, 32'h0000_0000);
      chk(rd, AIO_CTRL_RST);
      chk({hresp, hi_oe_n, lo_out}, 3'b010);
      ahb(1'b0, 8'h20, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask

   task automatic t_serial;
      logic [7:0] cmd [4] = '{AIO_CH_C_ON, AIO_CH_D_ON, AIO_CH_C_OFF, AIO_CH_D_OFF};
      logic [1:0] exp [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
      for (int i = 0; i < 4; i++) begin
         host.send_cmd(cmd[i]);
         @(posedge clock);
         chk({hi_oe_n, lo_out}, exp[i]);
      end
      ahb(1'b1, AIO_OFF_OUTS, 32'h0000_0003);
      @(posedge clock);
      chk({hi_oe_n, lo_out}, 2'b01);
      ahb(1'b0, AIO_OFF_OUTS, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      ahb(1'b1, AIO_OFF_OUTS, 32'h0000_0000);
   endtask

   // levels are taken at the query, later pin changes must not leak in
   task automatic t_query;
      pullup_lvl <= 1'b1;
      opto <= 1'b0;
      stop_n <= 1'b1;
      settle();
      ahb(1'b1, AIO_OFF_CMD, 32'h0000_0001);
      pullup_lvl <= 1'b0;
      opto <= 1'b1;
      stop_n <= 1'b0;
      settle();
      ahb(1'b0, AIO_OFF_REPLY, 32'h0000_0000);
      chk(rd, 32'h0101_0001);
      ahb(1'b0, AIO_OFF_REPLY, 32'h0000_0000);
      chk(rd, 32'h0001_0001);
      ahb(1'b1, AIO_OFF_CMD, 32'h0000_0001);
      ahb(1'b0, AIO_OFF_REPLY, 32'h0000_0000);
      chk(rd, 32'h0100_0100);
      pullup_lvl <= 1'b1;
      stop_n <= 1'b1;
      settle();
      host.send_byte(8'h3F);
      ahb(1'b0, AIO_OFF_REPLY, 32'h0000_0000);
      chk(rd, 32'h0101_0101);
   endtask

   task automatic t_func;
      for (int f = 0; f < 3; f++) begin
         ahb(1'b1, AIO_OFF_CTRL, 32'(f * 4 + 1));
         stop_n <= 1'b0;
         settle();
         chk({m_stop, m_inv}, {f == 1, f == 2});
         stop_n <= 1'b1;
         settle();
         chk({m_stop, m_inv}, 2'b00);
      end
   endtask

   task automatic t_modes;
      ser_in <= 1'b1;
      opto <= 1'b1;
      radio_on <= 1'b1;
      ahb(1'b1, AIO_OFF_CTRL, 32'h0000_0010);
      settle();
      chk({ch1_o, ch2_o, ch3_o, is_cmd, is_pos}, 5'b11001);
      radio_on <= 1'b0;
      ahb(1'b1, AIO_OFF_CTRL, 32'h0000_0012);
      settle();
      chk({ch1_o, ch2_o, ch3_o, is_cmd, is_pos}, 5'b00010);
      ahb(1'b1, AIO_OFF_CTRL, 32'h0000_0011);
      settle();
      chk({ch1_o, ch2_o, ch3_o, is_cmd, is_pos}, 5'b00001);
   endtask

   // short, long, short, long: high output follows, low output toggles on rise
   task automatic t_stick;
      int         w [4] = '{LO_W - 5, HI_W + 10, LO_W - 5, HI_W + 10};
      logic [1:0] exp [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
      radio_on <= 1'b1;
      ahb(1'b1, AIO_OFF_CTRL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         host.stick(w[i]);
         chk({hi_oe_n, lo_out}, exp[i]);
      end
      ahb(1'b0, AIO_OFF_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0024);
      ahb(1'b1, AIO_OFF_OUTS, 32'h0000_0003);
      @(posedge clock);
      chk({hi_oe_n, lo_out}, 2'b00);
   endtask

   initial begin
      failures = 0;
      num_checks = 0;
      clock = 1'b0;
      rst = 1'b1;
      {hsel, hwrite, radio_on, ser_in} = 4'b0000;
      {pullup_lvl, opto, stop_n} = 3'b101;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'b00;
      hsize = 3'b010;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_serial();
      t_query();
      t_func();
      t_modes();
      t_stick();
      wrap_up();
   end
endmodule
